/* hw/sgc_global_ctrl.sv */
// global control register bank with storm limiter, vid and led mapping
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "sgc_params.svh"

module sgc_global_ctrl #(
  parameter int NUM_PORTS      = 5,
  parameter int PERIOD_100_CYC = `SGC_PERIOD_100_MS * `SGC_CORE_CLK_MHZ * 1000
) (
  // clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  // register port
  input  wire logic [7:0]              i_addr,
  input  wire logic [7:0]              i_wr_data,
  input  wire logic                    i_wr_en,
  input  wire logic                    i_rd_en,
  output logic      [7:0]              o_rd_data,
  // strap pins
  input  wire logic                    i_duplex_strap_pin,
  input  wire logic                    i_flow_ctrl_strap_pin,
  input  wire logic                    i_speed_strap_pin,
  input  wire logic                    i_led_mode_strap_pin,
  // switch-side MII mode
  output sgc_pkg::sgc_mii_cfg_s        o_sw_mii,
  output logic                         o_special_tag_mode,
  output logic                         o_factory_setting,
  output logic      [10:0]             o_storm_threshold,
  // null vid replacement
  input  wire logic                    i_rx_vid_valid,
  input  wire logic [11:0]             i_rx_vlan_identifier,
  input  wire logic [11:0]             i_port_vlan_identifier,
  output logic                         o_vid_valid,
  output logic      [11:0]             o_vlan_identifier,
  // broadcast storm limiter, per port
  input  wire logic [NUM_PORTS-1:0]    i_port_storm_enable,
  input  wire logic [NUM_PORTS-1:0]    i_bcast_block,
  output logic      [NUM_PORTS-1:0]    o_storm_discard,
  // indicators, per port
  input  wire sgc_pkg::sgc_port_stat_s [NUM_PORTS-1:0] i_port_stat,
  output sgc_pkg::sgc_led_s            [NUM_PORTS-1:0] o_port_led
);

  // ****************************************************************
  // constants
  // ****************************************************************
  localparam int PERIOD_RATIO = `SGC_PERIOD_10_MS / `SGC_PERIOD_100_MS;
  localparam int TICK_W       = $clog2(PERIOD_100_CYC);
  localparam int SUB_W        = $clog2(PERIOD_RATIO);
  localparam logic [TICK_W-1:0] TICK_LAST =
    TICK_W'(PERIOD_100_CYC - 1);
  localparam logic [SUB_W-1:0]  SUB_LAST = SUB_W'(PERIOD_RATIO - 1);
  localparam logic [11:0]       VID_NULL = 12'h000;

  // ****************************************************************
  // registers
  // ****************************************************************
  logic       strap_taken;
  logic       back_pressure;
  logic       half_duplex;
  logic       flow_ctrl;
  logic       speed_10;
  logic       null_vid_replace;
  logic [2:0] storm_hi;
  logic [7:0] storm_lo;
  logic [7:0] factory_a;
  logic [7:0] factory_b;
  logic [7:0] factory_c;
  logic       factory_set;
  sgc_pkg::sgc_led_mode_e led_mode;
  logic       special_tag;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire hit_mii  = (i_addr == `SGC_OFS_MII_STORM_HI);
  wire hit_lo   = (i_addr == `SGC_OFS_STORM_LO);
  wire hit_fa   = (i_addr == `SGC_OFS_FACTORY_A);
  wire hit_fb   = (i_addr == `SGC_OFS_FACTORY_B);
  wire hit_fc   = (i_addr == `SGC_OFS_FACTORY_C);
  wire hit_led  = (i_addr == `SGC_OFS_LED_TAG);
  wire wr_mii   = i_wr_en & hit_mii;
  wire wr_lo    = i_wr_en & hit_lo;
  wire wr_fa    = i_wr_en & hit_fa;
  wire wr_fb    = i_wr_en & hit_fb;
  wire wr_fc    = i_wr_en & hit_fc;
  wire wr_led   = i_wr_en & hit_led;

  wire [7:0] rd_mii = {back_pressure, half_duplex, flow_ctrl, speed_10,
                       null_vid_replace, storm_hi};
  // reserved bits 7..3 read zero
  // reserved read zero
  wire [7:0] rd_led = {5'h00, factory_set, led_mode == sgc_pkg::SGC_LED_MODE_1,
                       special_tag};
  wire [7:0] next_rd_data =
    hit_mii ? rd_mii    :
    hit_lo  ? storm_lo  :
    hit_fa  ? factory_a :
    hit_fb  ? factory_b :
    hit_fc  ? factory_c :
    hit_led ? rd_led    : 8'h00;

  // ****************************************************************
  // strap capture and mode register
  // ****************************************************************
  // straps are loaded on the first edge after reset release
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      half_duplex <= 1'b0;
      flow_ctrl   <= 1'b0;
      speed_10    <= 1'b0;
    end else if (!strap_taken) begin
      half_duplex <= i_duplex_strap_pin;
      flow_ctrl   <= i_flow_ctrl_strap_pin;
      speed_10    <= i_speed_strap_pin;
    end else if (wr_mii) begin
      half_duplex <= i_wr_data[`SGC_BIT_HALF_DUPLEX];
      flow_ctrl   <= i_wr_data[`SGC_BIT_FLOW_CTRL];
      speed_10    <= i_wr_data[`SGC_BIT_SPEED_10];
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      back_pressure    <= 1'b0;
      null_vid_replace <= 1'b0;
      storm_hi         <= `SGC_RST_STORM_HI;
      storm_lo         <= `SGC_RST_STORM_LO;
    end else begin
      if (wr_mii) begin
        back_pressure    <= i_wr_data[`SGC_BIT_BACK_PRESSURE];
        null_vid_replace <= i_wr_data[`SGC_BIT_NULL_VID];
        storm_hi         <= i_wr_data[2:0];
      end
      if (wr_lo) begin
        storm_lo <= i_wr_data;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      factory_a <= `SGC_RST_FACTORY_A;
      factory_b <= `SGC_RST_FACTORY_B;
      factory_c <= `SGC_RST_FACTORY_C;
    end else begin
      if (wr_fa) factory_a <= i_wr_data;
      if (wr_fb) factory_b <= i_wr_data;
      if (wr_fc) factory_c <= i_wr_data;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      led_mode    <= sgc_pkg::SGC_LED_MODE_0;
      factory_set <= 1'b0;
      special_tag <= 1'b0;
    end else if (!strap_taken) begin
      led_mode <= sgc_pkg::sgc_led_mode_e'(i_led_mode_strap_pin);
    end else if (wr_led) begin
      led_mode    <= sgc_pkg::sgc_led_mode_e'(i_wr_data[`SGC_BIT_LED_MODE]);
      factory_set <= i_wr_data[`SGC_BIT_FACTORY_SET];
      special_tag <= i_wr_data[`SGC_BIT_SPECIAL_TAG];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= i_rd_en ? next_rd_data : 8'h00;
    end
  end

  // ****************************************************************
  // switch MII mode outputs
  // ****************************************************************
  // back pressure only meaningful in half duplex, pause only in full
  // back pressure
  assign o_sw_mii.back_pressure = back_pressure & half_duplex;
  assign o_sw_mii.half_duplex   = half_duplex;
  assign o_sw_mii.flow_ctrl     = flow_ctrl & ~half_duplex;
  assign o_sw_mii.speed_10      = speed_10;
  assign o_special_tag_mode     = special_tag;
  assign o_factory_setting      = factory_set;
  assign o_storm_threshold      = {storm_hi, storm_lo};

  // ****************************************************************
  // null vid replacement
  // ****************************************************************
  wire        vid_is_null = (i_rx_vlan_identifier == VID_NULL);
  wire [11:0] next_vid = (null_vid_replace && vid_is_null) ?
                         i_port_vlan_identifier : i_rx_vlan_identifier;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_vid_valid       <= 1'b0;
      o_vlan_identifier <= 12'h000;
    end else begin
      o_vid_valid       <= i_rx_vid_valid;
      o_vlan_identifier <= next_vid;
    end
  end

  // ****************************************************************
  // storm period base tick, 50 ms
  // ****************************************************************
  logic [TICK_W-1:0] tick_cnt;
  wire               tick = (tick_cnt == TICK_LAST);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + TICK_W'(1);
    end
  end

  // ****************************************************************
  // per-port storm limiter and indicators
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
      logic [SUB_W-1:0] sub_cnt;
      logic [11:0]      blk_cnt;
      logic             discard;
      wire  ten         = i_port_stat[p].ten_megabit_speed;
      wire  period_end  = tick & (~ten | (sub_cnt == SUB_LAST));
      wire  counting    = i_port_storm_enable[p] & i_bcast_block[p];
      wire  [11:0] next_blk = (blk_cnt == 12'hFFF) ? blk_cnt :
                              blk_cnt + 12'h001;
      wire  over = (next_blk > {1'b0, o_storm_threshold});

      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          sub_cnt <= '0;
        end else if (tick) begin
          sub_cnt <= (ten && sub_cnt != SUB_LAST) ?
                     sub_cnt + SUB_W'(1) : '0;
        end
      end

      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          blk_cnt <= 12'h000;
          discard <= 1'b0;
        end else if (period_end) begin
          blk_cnt <= 12'h000;
          discard <= 1'b0;
        end else if (counting) begin
          blk_cnt <= next_blk;
          discard <= discard | over;
        end else if (!i_port_storm_enable[p]) begin
          discard <= 1'b0;
        end
      end

      assign o_storm_discard[p] = discard & i_port_storm_enable[p];

      sgc_pkg::sgc_port_stat_s st;
      sgc_pkg::sgc_led_s       next_led;
      assign st = i_port_stat[p];
      wire lnk_act = st.link & ~st.activity;
      assign next_led = (led_mode == sgc_pkg::SGC_LED_MODE_0) ?
        '{port_indicator_two:  lnk_act,
          port_indicator_one:  st.full_duplex | st.collision,
          port_indicator_zero: st.link & ~st.ten_megabit_speed} :
        '{port_indicator_two:  lnk_act & ~st.ten_megabit_speed,
          port_indicator_one:  lnk_act & st.ten_megabit_speed,
          port_indicator_zero: st.link & st.full_duplex};

      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          o_port_led[p] <= '0;
        end else begin
          o_port_led[p] <= next_led;
        end
      end
    end
  endgenerate

endmodule : sgc_global_ctrl
`default_nettype wire

/* hw/sgc_params.svh */
// offsets, field positions, reset values and timing of the global controls
//
// Summary of operation
// - Back pressure bit 7 set applies half-duplex back pressure on switch MII.
// - Duplex bit 6 set selects half duplex, clear selects full duplex.
// - Flow control bit 5 set enables full-duplex flow control on switch MII.
// - Speed bit 4 set selects 10 Mbit/s, clear selects 100 Mbit/s.
// - Duplex, flow control and speed reset from their strap pin levels.
// - Null VLAN_IDENTIFIER replacement bit 3 swaps a null VLAN_IDENTIFIER for the port VLAN_IDENTIFIER.
// - Storm threshold is 11 bits of 64-byte blocks, high three bits first register.
// - Storm period is 50 ms at 100 Mbit/s and 500 ms at 10.
// - Storm threshold resets to upper bits 000 and low byte 0x4A.
// - Three factory test registers reset to 0x24, 0x28, 0x24; software leaves them.
// - Ninth register bits 7 to 3 read zero; bit 2 is writable, resets 0.
// - LED mode bit 1 picks indicator mapping; resets from its strap pin.
// - Bit 0 of ninth register enables special tag mode; resets to 0.
// - Storm limiting acts on a port only when its own enable bit is set.
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

// register offsets
`define SGC_OFS_MII_STORM_HI   8'h06
`define SGC_OFS_STORM_LO       8'h07
`define SGC_OFS_FACTORY_A      8'h08
`define SGC_OFS_FACTORY_B      8'h09
`define SGC_OFS_FACTORY_C      8'h0A
`define SGC_OFS_LED_TAG        8'h0B

// field positions
`define SGC_BIT_BACK_PRESSURE  7
`define SGC_BIT_HALF_DUPLEX    6
`define SGC_BIT_FLOW_CTRL      5
`define SGC_BIT_SPEED_10       4
`define SGC_BIT_NULL_VID       3
`define SGC_BIT_FACTORY_SET    2
`define SGC_BIT_LED_MODE       1
`define SGC_BIT_SPECIAL_TAG    0

// reset values
`define SGC_RST_STORM_HI       3'h0
`define SGC_RST_STORM_LO       8'h4A
`define SGC_RST_FACTORY_A      8'h24
`define SGC_RST_FACTORY_B      8'h28
`define SGC_RST_FACTORY_C      8'h24

// timing
`define SGC_CORE_CLK_MHZ       250
`define SGC_PERIOD_100_MS      50
`define SGC_PERIOD_10_MS       500

`endif

/* hw/sgc_pkg.sv */
// types shared by the global control register bank
package sgc_pkg;

  // switch-side MII operating mode
  typedef struct packed {
    logic back_pressure;
    logic half_duplex;
    logic flow_ctrl;
    logic speed_10;
  } sgc_mii_cfg_s;

  // per-port link status feeding the indicators
  typedef struct packed {
    logic link;
    logic activity;
    logic full_duplex;
    logic collision;
    logic ten_megabit_speed;
  } sgc_port_stat_s;

  // per-port indicator outputs
  typedef struct packed {
    logic port_indicator_two;
    logic port_indicator_one;
    logic port_indicator_zero;
  } sgc_led_s;

  typedef enum logic {
    SGC_LED_MODE_0,
    SGC_LED_MODE_1
  } sgc_led_mode_e;

endpackage : sgc_pkg

/* tb/sgc_global_ctrl_assertions.sv */
// port relations of the global control register bank
`timescale 1ns/1ns
`default_nettype none
module sgc_global_ctrl_chk #(
  parameter int NUM_PORTS = 5
) (
  // clock, reset and register port
  input wire logic                  i_core_clk,
  input wire logic                  i_reset,
  input wire logic [7:0]            i_addr,
  input wire logic [7:0]            i_wr_data,
  input wire logic                  i_wr_en,
  input wire logic                  i_rd_en,
  input wire logic [7:0]            o_rd_data,
  // watched outputs and their causes
  input wire sgc_pkg::sgc_mii_cfg_s o_sw_mii,
  input wire logic                  o_special_tag_mode,
  input wire logic                  o_factory_setting,
  input wire logic [10:0]           o_storm_threshold,
  input wire logic                  i_rx_vid_valid,
  input wire logic [11:0]           i_rx_vlan_identifier,
  input wire logic [11:0]           o_vlan_identifier,
  input wire logic [NUM_PORTS-1:0]  i_port_storm_enable,
  input wire logic [NUM_PORTS-1:0]  o_storm_discard
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  property p_bp;
    o_sw_mii.back_pressure |-> o_sw_mii.half_duplex;
  endproperty
  a_bp: assert property (p_bp)
    else $error("back pressure in full duplex");
  property p_fc;
    o_sw_mii.flow_ctrl |-> !o_sw_mii.half_duplex;
  endproperty
  a_fc: assert property (p_fc)
    else $error("flow control in half duplex");
  property p_mode;
    i_wr_en && i_addr == 8'h06 |=> o_sw_mii.half_duplex == $past(i_wr_data[6])
      && o_sw_mii.speed_10 == $past(i_wr_data[4]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mii mode not taken from write");
  property p_thr;
    i_wr_en && i_addr == 8'h07 |=> o_storm_threshold ==
      {$past(o_storm_threshold[10:8]), $past(i_wr_data)};
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold low byte wrong");
  property p_thr_rst;
    $fell(i_reset) |-> o_storm_threshold == 11'h04A;
  endproperty
  a_thr_rst: assert property (p_thr_rst)
    else $error("threshold reset value wrong");
  property p_ro;
    $past(i_rd_en) && $past(i_addr) == 8'h0B |-> o_rd_data[7:3] == 5'h00;
  endproperty
  a_ro: assert property (p_ro)
    else $error("reserved bits read nonzero");
  property p_tag;
    i_wr_en && i_addr == 8'h0B |=> o_special_tag_mode == $past(i_wr_data[0])
      && o_factory_setting == $past(i_wr_data[2]);
  endproperty
  a_tag: assert property (p_tag)
    else $error("tag or factory bit not written");
  property p_vid;
    i_rx_vid_valid && i_rx_vlan_identifier != 12'h000 |=>
      o_vlan_identifier == $past(i_rx_vlan_identifier);
  endproperty
  a_vid: assert property (p_vid)
    else $error("non-null vid altered");
  property p_gate;
    (o_storm_discard & ~i_port_storm_enable) == '0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("discard on disabled port");
endmodule : sgc_global_ctrl_chk
bind sgc_global_ctrl sgc_global_ctrl_chk #(.NUM_PORTS(NUM_PORTS)) chk_inst (
  .i_core_clk, .i_reset, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en,
  .o_rd_data, .o_sw_mii, .o_special_tag_mode, .o_factory_setting,
  .o_storm_threshold, .i_rx_vid_valid, .i_rx_vlan_identifier,
  .o_vlan_identifier, .i_port_storm_enable, .o_storm_discard);
`default_nettype wire

/* tb/sgc_global_ctrl_tb.sv */
// self-checking bench of the global control register bank
`timescale 1ns/1ns
`default_nettype none
module sgc_global_ctrl_tb;
  localparam int NP = 5;
  localparam int PER = 20;
  localparam logic [NP-1:0] P0 = {{(NP-1){1'b0}}, 1'b1};
  localparam logic [7:0] ADR [8] = '{8'h05, 8'h06, 8'h07, 8'h08,
                                     8'h09, 8'h0A, 8'h0B, 8'h0C};
  localparam logic [7:0] EXP1 [8] = '{8'h00, 8'h70, 8'h4A, 8'h24,
                                      8'h28, 8'h24, 8'h02, 8'h00};
  localparam logic [7:0] EXP0 [8] = '{8'h00, 8'h00, 8'h4A, 8'h24,
                                      8'h28, 8'h24, 8'h00, 8'h00};
  logic                             i_core_clk = 1'b0;
  logic                             i_reset    = 1'b1;
  logic [7:0]                       i_addr     = 8'h00;
  logic [7:0]                       i_wr_data  = 8'h00;
  logic                             i_wr_en    = 1'b0;
  logic                             i_rd_en    = 1'b0;
  logic [3:0]                       strap      = 4'h0;
  logic                             vid_v      = 1'b0;
  logic [11:0]                      rx_vid     = 12'h000;
  logic [11:0]                      pt_vid     = 12'h000;
  logic [NP-1:0]                    storm_en   = '0;
  logic [NP-1:0]                    blk        = '0;
  sgc_pkg::sgc_port_stat_s [NP-1:0] stat       = '0;
  logic [7:0]                       o_rd_data;
  sgc_pkg::sgc_mii_cfg_s            o_sw_mii;
  logic                             o_tag, o_fac, o_vid_v, rd_d = 1'b0;
  logic [10:0]                      o_thr;
  logic [11:0]                      o_vid;
  logic [NP-1:0]                    o_disc;
  sgc_pkg::sgc_led_s [NP-1:0]       o_led;
  logic [31:0]                      rnd;
  logic [3:0]                       m;
  logic [7:0]                       exp_q [$];
  int err_total = 0;
  int tests_run = 0;
  int seed = 37;
  int cnt;
  always #2 i_core_clk = ~i_core_clk;
  sgc_global_ctrl #(.NUM_PORTS(NP), .PERIOD_100_CYC(PER)) sgc_global_ctrl_inst (
    .i_core_clk, .i_reset, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en,
    .o_rd_data, .i_duplex_strap_pin(strap[2]), .i_flow_ctrl_strap_pin(strap[3]),
    .i_speed_strap_pin(strap[1]), .i_led_mode_strap_pin(strap[0]),
    .o_sw_mii, .o_special_tag_mode(o_tag), .o_factory_setting(o_fac),
    .o_storm_threshold(o_thr), .i_rx_vid_valid(vid_v),
    .i_rx_vlan_identifier(rx_vid), .i_port_vlan_identifier(pt_vid),
    .o_vid_valid(o_vid_v), .o_vlan_identifier(o_vid),
    .i_port_storm_enable(storm_en), .i_bcast_block(blk),
    .o_storm_discard(o_disc), .i_port_stat(stat), .o_port_led(o_led));
  // ****
  // bus tasks and read monitor
  // ****
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic we, re, input logic [7:0] a, d);
    i_wr_en <= we;
    i_rd_en <= re;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_core_clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle
  task automatic do_reset(input logic [3:0] s);
    strap <= s;
    i_reset <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_reset <= 1'b0;
    idle(2);
  endtask : do_reset
  always @(posedge i_core_clk) rd_d <= i_rd_en;
  always @(negedge i_core_clk) begin
    if (rd_d) check({4'h0, o_rd_data}, {4'h0, exp_q.pop_front()});
  end
  // three blocks after a period start, then time the discard
  task automatic storm(input int lo, hi);
    blk <= '1;
    repeat (250) begin
      @(negedge i_core_clk);
      if (o_disc[0] === 1'b1) break;
    end
    check({11'h0, o_disc[1]}, 12'h000);
    @(posedge i_core_clk);
    blk <= '0;
    repeat (250) begin
      @(negedge i_core_clk);
      if (o_disc[0] === 1'b0) break;
    end
    @(posedge i_core_clk);
    blk <= P0;
    repeat (3) @(negedge i_core_clk);
    check({11'h0, o_disc[0]}, 12'h000);
    @(posedge i_core_clk);
    blk <= '0;
    @(negedge i_core_clk);
    check({11'h0, o_disc[0]}, 12'h001);
    cnt = 0;
    while (o_disc[0] === 1'b1 && cnt < 250) begin
      @(negedge i_core_clk);
      cnt++;
    end
    check({11'h0, cnt >= lo && cnt <= hi}, 12'h001);
    @(posedge i_core_clk);
  endtask : storm
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // run takes about 550 cycles; allow well over ten times that
  initial begin
    #150000;
    err_total++;
    conclude();
  end
  initial begin
    rnd = $random(seed);
    stat <= {rnd[NP*5-1:1], 1'b0};
    for (int s = 1; s >= 0; s--) begin
      do_reset(s[0] ? 4'hF : 4'h0);
      check({1'b0, o_thr}, 12'h04A);
      check({8'h0, o_sw_mii}, s[0] ? 12'h005 : 12'h000);
      foreach (ADR[i]) rd(ADR[i], s[0] ? EXP1[i] : EXP0[i]);
      idle(1);
    end
    $display("test reset values done");
    // mode 0 indicator mapping, strap low
    check({9'h0, o_led[1]},
          {9'h0, stat[1].link & ~stat[1].activity,
           stat[1].full_duplex | stat[1].collision,
           stat[1].link & ~stat[1].ten_megabit_speed});
    wr(8'h0B, 8'hFF);
    wr(8'h0C, 8'hFF);
    rd(8'h0B, 8'h07);
    rd(8'h0C, 8'h00);
    check({10'h0, o_tag, o_fac}, 12'h003);
    check({9'h0, o_led[1]},
          {9'h0,
           stat[1].link & ~stat[1].activity & ~stat[1].ten_megabit_speed,
           stat[1].link & ~stat[1].activity & stat[1].ten_megabit_speed,
           stat[1].link & stat[1].full_duplex});
    for (int i = 3; i < 6; i++) begin
      rnd = $random(seed);
      wr(ADR[i], rnd[7:0]);
      rd(ADR[i], rnd[7:0]);
      wr(ADR[i], EXP1[i]);
    end
    $display("test access kinds done");
    for (int v = 0; v < 16; v++) begin
      m = v[3:0];
      wr(8'h06, {m, 4'h0});
      rd(8'h06, {m, 4'h0});
      check({8'h0, o_sw_mii}, {8'h0, m[3] & m[2], m[2], m[1] & ~m[2], m[0]});
    end
    wr(8'h06, 8'h05);
    wr(8'h07, 8'hC3);
    idle(1);
    check({1'b0, o_thr}, 12'h5C3);
    $display("test mode and threshold done");
    for (int k = 0; k < 3; k++) begin
      rnd = $random(seed);
      wr(8'h06, k == 2 ? 8'h00 : 8'h08);
      pt_vid <= rnd[11:0] | 12'h001;
      rx_vid <= k == 1 ? (rnd[23:12] | 12'h800) : 12'h000;
      vid_v <= 1'b1;
      idle(1);
      vid_v <= 1'b0;
      @(negedge i_core_clk);
      check(o_vid, k == 0 ? pt_vid : rx_vid);
      check({11'h0, o_vid_v}, 12'h001);
      @(posedge i_core_clk);
    end
    $display("test vid replacement done");
    wr(8'h07, 8'h02);
    storm_en <= P0;
    idle(1);
    storm(PER - 8, PER);
    stat[0].ten_megabit_speed <= 1'b1;
    storm(10 * PER - 8, 10 * PER);
    $display("test storm limiter done");
    conclude();
  end
endmodule : sgc_global_ctrl_tb
`default_nettype wire
